// ---- rtl/sqt_pkg.sv ----
package sqt_pkg;
    // Register addresses, low three address bits only.
    localparam logic [2:0] ADDR_CMD_STATUS = 3'h0;
    localparam logic [2:0] ADDR_CNT_LOW    = 3'h4;
    localparam logic [2:0] ADDR_CNT_HIGH   = 3'h5;
    localparam logic [2:0] ADDR_IRQ_MASK   = 3'h6;
    localparam logic [2:0] ADDR_IRQ_STAT   = 3'h7;
    // Command byte timer field position.
    localparam int CMD_TIMER_LSB = 6;
    // Status byte timer bit.
    localparam int STAT_TIMER_BIT = 6;
    // Count field width and mode field position in the 16-bit word.
    localparam int CNT_W        = 14;
    localparam int MODE_LSB     = 14;
    // Terminal value of the down-counter.
    localparam logic [13:0] CNT_TERMINAL = 14'h0002;
    // Reset values.
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [13:0] RST_COUNT = 14'h0000;
    localparam logic [1:0]  RST_IRQ   = 2'h0;

    // Timer commands.
    typedef enum logic [1:0] {
        SQT_CMD_NOP      = 2'b00,
        SQT_CMD_STOP     = 2'b01,
        SQT_CMD_STOP_TC  = 2'b10,
        SQT_CMD_START    = 2'b11
    } sqt_cmd_t;

    // Output modes.
    typedef enum logic [1:0] {
        SQT_MODE_SQ_ONCE  = 2'b00,
        SQT_MODE_SQ_CONT  = 2'b01,
        SQT_MODE_PLS_ONCE = 2'b10,
        SQT_MODE_PLS_CONT = 2'b11
    } sqt_mode_t;

    // Run state.
    typedef enum logic [1:0] {
        SQT_ST_IDLE = 2'b00,
        SQT_ST_RUN  = 2'b01
    } sqt_state_t;
endpackage

// ---- rtl/sqt_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module sqt_timer (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic      [7:0] rdata,
    input  wire logic       timer_in,
    output logic            timer_out,
    output logic            irq
);
    // Input pin synchroniser; a pulse counts when stages two and three agree.
    logic [2:0] tin_sync_q;
    logic       tin_level_q;
    logic [2:0] tin_sync_d;
    logic       tin_level_d;
    logic       tin_fall;

    // Counting and control state.
    sqt_pkg::sqt_state_t state_q, state_d;
    logic [13:0] len_q, len_d;           // Written count length, not yet in use.
    logic [1:0]  lmode_q, lmode_d;       // Written mode, not yet in use.
    logic [13:0] cnt_q, cnt_d;           // Live down-counter.
    logic [13:0] alen_q, alen_d;         // Active count length.
    logic [1:0]  amode_q, amode_d;       // Active mode.
    logic        half_q, half_d;         // 0: first (high) half, 1: second half.
    logic        pend_start_q, pend_start_d;
    logic        pend_stop_q, pend_stop_d;
    logic        tout_q, tout_d;
    logic        tc_flag_q, tc_flag_d;   // Status bit six, cleared by status read.
    logic [1:0]  istat_q, istat_d;       // Sticky: bit0 terminal count, bit1 stop.
    logic [1:0]  imask_q, imask_d;
    logic        irq_q, irq_d;
    logic [7:0]  rdata_q, rdata_d;

    // Shared decode terms.
    logic        wr_cmd;
    logic [1:0]  cmd;
    logic        tc_hit;
    logic        ev_tc;
    logic        ev_stop;
    logic [13:0] half_start;

    assign tin_sync_d  = {tin_sync_q[1:0], timer_in};
    assign tin_level_d = (tin_sync_q[2] == tin_sync_q[1]) ? tin_sync_q[2] : tin_level_q;
    // Counting on the falling edge of the filtered input pulse.
    assign tin_fall    = tin_level_q & ~tin_level_d;

    assign wr_cmd = wr_stb && (addr[2:0] == sqt_pkg::ADDR_CMD_STATUS);
    assign cmd    = wdata[sqt_pkg::CMD_TIMER_LSB +: 2];
    assign tc_hit = (state_q == sqt_pkg::SQT_ST_RUN) && tin_fall
                    && (cnt_q <= sqt_pkg::CNT_TERMINAL);

    // Start value of a half: first half of an odd length gets one extra pulse.
    // The counter counts by two; odd first halves start at len+1 so that
    // (len+1)/2 pulses elapse, second half at len-1 giving (len-1)/2.
    function automatic logic [13:0] half_init(input logic [13:0] len, input logic second);
        logic [13:0] v;
        v = len;
        if (len[0]) begin
            v = second ? (len - 14'h0001) : (len + 14'h0001);
        end
        return v;
    endfunction

    assign half_start = half_init(alen_q, 1'b1);

    // Next-state logic for the counter, command decode and software registers.
    always_comb begin
        state_d      = state_q;
        len_d        = len_q;
        lmode_d      = lmode_q;
        cnt_d        = cnt_q;
        alen_d       = alen_q;
        amode_d      = amode_q;
        half_d       = half_q;
        pend_start_d = pend_start_q;
        pend_stop_d  = pend_stop_q;
        tout_d       = tout_q;
        tc_flag_d    = tc_flag_q;
        imask_d      = imask_q;
        ev_tc        = 1'b0;
        ev_stop      = 1'b0;

        // Count length writes only latch; the counter sees them only after a start command.
        if (wr_stb && addr[2:0] == sqt_pkg::ADDR_CNT_LOW) begin
            len_d[7:0] = wdata;
        end
        if (wr_stb && addr[2:0] == sqt_pkg::ADDR_CNT_HIGH) begin
            len_d[13:8] = wdata[5:0];
            lmode_d     = wdata[7:6];
        end
        if (wr_stb && addr[2:0] == sqt_pkg::ADDR_IRQ_MASK) begin
            imask_d = wdata[1:0];
        end

        // Counting: each input pulse while above the terminal value removes two.
        if (state_q == sqt_pkg::SQT_ST_RUN && tin_fall) begin
            if (tc_hit) begin
                // Every mode passes the count twice, so one output cycle takes the
                // programmed number of pulses; only the output shape differs.
                if (!half_q) begin
                    // End of the first half: square goes low, pulse stays high.
                    half_d = 1'b1;
                    tout_d = amode_q[1];
                    cnt_d  = half_start;
                end else begin
                    // Cycle end: square goes high, pulse goes low for one input period.
                    ev_tc  = 1'b1;
                    half_d = 1'b0;
                    tout_d = ~amode_q[1];
                    cnt_d  = half_init(alen_q, 1'b0);
                end
            end else begin
                cnt_d = cnt_q - 14'h0002;
                if (amode_q[1]) begin
                    tout_d = 1'b1;
                end
            end
        end

        // A halted pulse output still ends its low period at the next input fall,
        // so the last terminal-count pulse keeps its full width.
        if (state_q == sqt_pkg::SQT_ST_IDLE && tin_fall && amode_q[1]) begin
            tout_d = 1'b1;
        end

        // Actions at the end of a full output cycle.
        if (ev_tc) begin
            tc_flag_d = 1'b1;
            if (pend_start_q) begin
                pend_start_d = 1'b0;
                pend_stop_d  = 1'b0;
                alen_d       = len_q;
                amode_d      = lmode_q;
                half_d       = 1'b0;
                tout_d       = ~(amode_q[1] & lmode_q[1]); // Keep the pulse only if pulsing on.
                cnt_d        = half_init(len_q, 1'b0);
            end else if (pend_stop_q || amode_q == sqt_pkg::SQT_MODE_SQ_ONCE
                         || amode_q == sqt_pkg::SQT_MODE_PLS_ONCE) begin
                pend_stop_d = 1'b0;
                state_d     = sqt_pkg::SQT_ST_IDLE;
                ev_stop     = 1'b1;
            end
        end

        // Timer commands; all ignored in the idle state except start.
        if (wr_cmd) begin
            case (cmd)
                sqt_pkg::SQT_CMD_STOP: begin
                    if (state_q == sqt_pkg::SQT_ST_RUN) begin
                        state_d      = sqt_pkg::SQT_ST_IDLE;
                        pend_start_d = 1'b0;
                        pend_stop_d  = 1'b0;
                        ev_stop      = 1'b1;
                    end
                end
                sqt_pkg::SQT_CMD_STOP_TC: begin
                    if (state_q == sqt_pkg::SQT_ST_RUN) begin
                        pend_stop_d  = 1'b1;
                        pend_start_d = 1'b0;
                    end
                end
                sqt_pkg::SQT_CMD_START: begin
                    if (state_q == sqt_pkg::SQT_ST_IDLE) begin
                        state_d = sqt_pkg::SQT_ST_RUN;
                        alen_d  = len_q;
                        amode_d = lmode_q;
                        half_d  = 1'b0;
                        tout_d  = 1'b1;
                        cnt_d   = half_init(len_q, 1'b0);
                    end else begin
                        pend_start_d = 1'b1;
                        pend_stop_d  = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // A status read clears the timer flag unless it is set again now.
        if (rd_stb && addr[2:0] == sqt_pkg::ADDR_CMD_STATUS && !ev_tc) begin
            tc_flag_d = 1'b0;
        end
    end

    // Interrupt status: set wins over write-one-to-clear.
    always_comb begin
        istat_d = istat_q;
        if (wr_stb && addr[2:0] == sqt_pkg::ADDR_IRQ_STAT) begin
            istat_d = istat_q & ~wdata[1:0];
        end
        istat_d = istat_d | {ev_stop, ev_tc};
        irq_d   = |(istat_d & imask_d);
    end

    // Read data: counter word with active mode on top.
    always_comb begin
        rdata_d = rdata_q;
        if (rd_stb) begin
            case (addr[2:0])
                sqt_pkg::ADDR_CMD_STATUS: rdata_d = {1'b0, tc_flag_q, 6'h00};
                sqt_pkg::ADDR_CNT_LOW:    rdata_d = cnt_q[7:0];
                sqt_pkg::ADDR_CNT_HIGH:   rdata_d = {amode_q, cnt_q[13:8]};
                sqt_pkg::ADDR_IRQ_MASK:   rdata_d = {6'h00, imask_q};
                sqt_pkg::ADDR_IRQ_STAT:   rdata_d = {6'h00, istat_q};
                default:                  rdata_d = 8'h00;
            endcase
        end
    end

    // Registers; reset stops the timer but keeps count contents undefined-free.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tin_sync_q   <= 3'h0;
            tin_level_q  <= 1'b0;
            state_q      <= sqt_pkg::SQT_ST_IDLE;
            len_q        <= sqt_pkg::RST_COUNT;
            lmode_q      <= 2'h0;
            cnt_q        <= sqt_pkg::RST_COUNT;
            alen_q       <= sqt_pkg::RST_COUNT;
            amode_q      <= 2'h0;
            half_q       <= 1'b0;
            pend_start_q <= 1'b0;
            pend_stop_q  <= 1'b0;
            tout_q       <= 1'b1;
            tc_flag_q    <= 1'b0;
            istat_q      <= sqt_pkg::RST_IRQ;
            imask_q      <= sqt_pkg::RST_IRQ;
            irq_q        <= 1'b0;
            rdata_q      <= sqt_pkg::RST_BYTE;
        end else begin
            tin_sync_q   <= tin_sync_d;
            tin_level_q  <= tin_level_d;
            state_q      <= state_d;
            len_q        <= len_d;
            lmode_q      <= lmode_d;
            cnt_q        <= cnt_d;
            alen_q       <= alen_d;
            amode_q      <= amode_d;
            half_q       <= half_d;
            pend_start_q <= pend_start_d;
            pend_stop_q  <= pend_stop_d;
            tout_q       <= tout_d;
            tc_flag_q    <= tc_flag_d;
            istat_q      <= istat_d;
            imask_q      <= imask_d;
            irq_q        <= irq_d;
            rdata_q      <= rdata_d;
        end
    end

    assign rdata     = rdata_q;
    assign timer_out = tout_q;
    assign irq       = irq_q;

    // Checks on the control sequencing.
    nop_no_effect_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_cmd && cmd == sqt_pkg::SQT_CMD_NOP && !tin_fall) |=> $stable(state_q))
        else $error("Null command changed the run state.");
    stop_halts_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_cmd && cmd == sqt_pkg::SQT_CMD_STOP) |=> state_q == sqt_pkg::SQT_ST_IDLE)
        else $error("Stop command left the counter running.");
    start_loads_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_cmd && cmd == sqt_pkg::SQT_CMD_START && state_q == sqt_pkg::SQT_ST_IDLE)
        |=> (state_q == sqt_pkg::SQT_ST_RUN && alen_q == $past(len_q)))
        else $error("Idle start did not load and run.");
    len_isolated_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!(wr_cmd && cmd == sqt_pkg::SQT_CMD_START) && !pend_start_q) |=> $stable(alen_q))
        else $error("Active length changed without a start.");
    step_two_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_q == sqt_pkg::SQT_ST_RUN && tin_fall && !tc_hit && !wr_cmd)
        |=> cnt_q == $past(cnt_q) - 14'h0002)
        else $error("Counter did not step by two.");
    reset_idle_a: assert property (@(posedge sys_clk)
        !rst_n |=> state_q == sqt_pkg::SQT_ST_IDLE)
        else $error("Reset did not stop the counter.");
    stop_tc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ev_tc && pend_stop_q && !pend_start_q && !wr_cmd) |=> state_q == sqt_pkg::SQT_ST_IDLE)
        else $error("Stop after terminal count did not halt.");
    status_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rd_stb && addr[2:0] == sqt_pkg::ADDR_CMD_STATUS) |=> rdata[6] == $past(tc_flag_q))
        else $error("Status bit six does not show the timer flag.");
    pulse_width_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (amode_q[1] && !tout_q && tin_fall) |=> tout_q)
        else $error("Terminal count pulse lasted more than one input period.");
endmodule
`default_nettype wire

// ---- verification/sqt_pulse_src.sv ----
`timescale 1ns/10ps
`default_nettype none
// Count source: a square wave on the count pin, unrelated in phase to sys_clk.
module sqt_pulse_src #(
    parameter int HALF_NS = 800
) (
    input  wire logic run,
    output logic      pin
);
    // Parks high while halted, so a halt never fakes a falling edge.
    initial begin
        pin = 1'b1;
        #37;
        forever begin
            #HALF_NS pin = run ? ~pin : 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- verification/sqt_timer_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module sqt_timer_test;
    logic       sys_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr_stb = 1'b0;
    logic       rd_stb = 1'b0;
    logic       run = 1'b0;
    logic [7:0] rdata;
    logic       timer_in;
    logic       timer_out;
    logic       irq;
    int         num_errors = 0;
    int         cmp_count = 0;

    // A 100 ns clock.
    always #50 sys_clk = ~sys_clk;

    sqt_timer u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .timer_in(timer_in),
        .timer_out(timer_out), .irq(irq));
    sqt_pulse_src u_src (.run(run), .pin(timer_in));

    task automatic tally_and_finish();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: got %0h expected %0h", $time, msg, got, exp);
        end
    endtask

    // Bus cycles; the trailing edge keeps a strobe from being set twice in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Upper address bits are set on purpose, since only the low three decode.
    task automatic prog(input logic [1:0] m, input logic [13:0] n, input logic [1:0] c);
        wr(8'hF4, n[7:0]);
        wr(8'h0D, {m, n[13:8]});
        wr(8'hA8, {c, 6'h00});
    endtask

    // Counts count-pin falls until the output level changes, bounded.
    task automatic seg(output int n);
        logic lv;
        logic pi;
        int   i;
        n  = 0;
        lv = timer_out;
        pi = timer_in;
        for (i = 0; i < 3000 && timer_out === lv; i++) begin
            @(posedge sys_clk);
            #1;
            if (pi === 1'b1 && timer_in === 1'b0) n++;
            pi = timer_in;
        end
        if (timer_out === lv) begin
            num_errors++;
            $display("[FAIL] %0t output never toggled", $time);
            tally_and_finish();
        end
    endtask

    task automatic seg_chk(input int exp, input string msg);
        int n;
        seg(n);
        check(n, exp, msg);
    endtask

    // Output must hold still for the given number of cycles.
    task automatic quiet(input int cyc);
        logic lv;
        int   bad;
        lv  = timer_out;
        bad = 0;
        repeat (cyc) begin
            @(posedge sys_clk);
            #1;
            if (timer_out !== lv) bad++;
        end
        check(bad, 0, "output moved");
    endtask

    task automatic t_reset();
        int n;
        @(posedge sys_clk);
        #1;
        check({timer_out, irq, rdata}, 10'h200, "reset outputs");
        quiet(300);
        prog(2'h1, 14'd6, 2'h3);
        seg(n);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        check(timer_out, 1'b1, "idle after reset");
        quiet(400);
    endtask

    // Every mode with an odd length; continuous ones are stopped just after a rise.
    task automatic t_modes();
        int n;
        for (int m = 0; m < 4; m++) begin
            prog(m[1:0], 14'd5, 2'h3);
            seg(n);
            seg_chk(m[1] ? 1 : 2, "low part");
            if (m[0]) begin
                seg_chk(m[1] ? 4 : 3, "high part");
                seg_chk(m[1] ? 1 : 2, "low part");
                wr(8'h00, 8'h40);
                quiet(300);
            end else begin
                quiet(400);
                check(timer_out, 1'b1, "single wave end");
            end
        end
    endtask

    // New length held back until start, then taken at the cycle end.
    task automatic t_reload();
        int n;
        prog(2'h1, 14'd4, 2'h3);
        seg(n);
        seg(n);
        wr(8'h04, 8'h08);
        wr(8'h00, 8'h00);
        seg_chk(2, "old length kept");
        seg_chk(2, "old length kept");
        wr(8'h00, 8'hC0);
        seg(n);
        seg(n);
        seg_chk(4, "new length");
        seg_chk(4, "new length");
        seg(n);
        if (timer_out !== 1'b0) seg(n);
        wr(8'h00, 8'h80);
        seg_chk(4, "finish cycle");
        quiet(300);
        check(timer_out, 1'b1, "halt level");
        wr(8'h00, 8'h40);
        wr(8'h00, 8'h80);
        quiet(300);
    endtask

    task automatic t_readback();
        logic [7:0] a;
        logic [7:0] b;
        int         n;
        prog(2'h1, 14'd40, 2'h3);
        seg(n);
        repeat (48) @(posedge sys_clk);
        rd(8'h04, a);
        repeat (14) @(posedge sys_clk);
        rd(8'h04, b);
        check(a - b, 8'h02, "step per pulse");
        wr(8'h00, 8'h40);
        rd(8'h04, a);
        rd(8'h05, b);
        check(b, 8'h40, "mode over count");
        check({a[0], a >= 8'h02 && a <= 8'h28}, 2'h1, "live count");
    endtask

    task automatic t_status_irq();
        logic [7:0] a;
        int         n;
        wr(8'h07, 8'h03);
        prog(2'h1, 14'd4, 2'h3);
        wr(8'h06, 8'h01);
        rd(8'h00, a);
        seg(n);
        rd(8'h00, a);
        check(a[6], 1'b0, "flag before terminal count");
        check(irq, 1'b0, "irq before event");
        seg(n);
        rd(8'h00, a);
        check(a[6], 1'b1, "status timer bit");
        rd(8'h00, a);
        check(a[6], 1'b0, "status cleared by read");
        check(irq, 1'b1, "irq raised");
        wr(8'h00, 8'h40);
        rd(8'h07, a);
        check(a[1:0], 2'h3, "sticky events");
        wr(8'h06, 8'h00);
        repeat (2) @(posedge sys_clk);
        #1;
        check(irq, 1'b0, "irq masked");
        wr(8'h07, 8'h03);
        wr(8'h06, 8'h03);
        repeat (2) @(posedge sys_clk);
        #1;
        check(irq, 1'b0, "irq cleared");
        rd(8'h01, a);
        check(a, 8'h00, "unmapped read");
    endtask

    // Main sequence; reset is held for four cycles.
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        run   <= 1'b1;
        t_reset();
        t_modes();
        t_reload();
        t_readback();
        t_status_irq();
        tally_and_finish();
    end
endmodule
`default_nettype wire
